// >>> common/cwf_defines.vh
`ifndef CWF_DEFINES_VH
`define CWF_DEFINES_VH
// ==========================================================
// Register map (byte addresses)
`define CWF_ADDR_CTRL0      8'h00
`define CWF_ADDR_CTRL1      8'h04
`define CWF_ADDR_PERIOD     8'h08
`define CWF_ADDR_STATUS     8'h0c
`define CWF_ADDR_W          8
// ==========================================================
// Field positions
`define CWF_CNT_W           3
`define CWF_CNT_LSB         4
`define CWF_CNT_MSB         6
`define CWF_PER_W           8
`define CWF_PER_MSB         7
`define CWF_C1_EN           0
`define CWF_C1_OPE          1
`define CWF_C1_SPEED        4
`define CWF_C1_WE           6
`define CWF_C1_SE           7
`define CWF_ST_FOUT         0
`define CWF_ST_FALL         1
`define CWF_ST_RISE         2
`define CWF_ST_FALL_IE      3
`define CWF_ST_RISE_IE      4
// ==========================================================
// Constants and reset values
`define CWF_CNT_ONE         3'h1
`define CWF_CNT_ZERO        3'h0
`define CWF_PER_ZERO        8'h00
`define CWF_PER_ONE         8'h01
`define CWF_RST_CTRL0       3'h0
`define CWF_RST_CTRL1       8'h00
`define CWF_RST_PERIOD      8'h00
`define CWF_RST_STATUS      5'h00
// ==========================================================
// Operating modes
`define CWF_MODE_W          3
`define CWF_M_DISABLED      3'h0
`define CWF_M_CONT          3'h1
`define CWF_M_SAMPLED       3'h2
`define CWF_M_SFILT         3'h3
`define CWF_M_WINDOW        3'h4
`define CWF_M_WRESAMP       3'h5
`define CWF_M_WFILT         3'h6
`define CWF_M_ILLEGAL       3'h7
`endif

// >>> rtl/cwf_sample_filter.v
`timescale 1ns/1ns
`include "cwf_defines.vh"
// ==========================================================
// Consecutive-agreement filter as a sample counter
module cwf_sample_filter (
    input  wire                  pclk,         // Bus clock
    input  wire                  presetn,      // Async reset, low active
    input  wire                  ce,           // Clock enable
    input  wire                  active,       // Filter running
    input  wire                  sample_tick,  // Take one sample
    input  wire                  din,          // Sampled level
    input  wire [`CWF_CNT_W-1:0] agree_count,  // Samples needed
    output reg                   dout          // Filtered level
);
    reg [`CWF_CNT_W-1:0] agree_ctr;
    // Count samples differing from output; any agreeing sample restarts it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            agree_ctr <= `CWF_CNT_ZERO;
            dout      <= 1'b0;
        end else if (ce) begin
            if (!active) begin
                agree_ctr <= `CWF_CNT_ZERO; // R25
                dout      <= 1'b0; // R10
            end else if (sample_tick) begin
                if (din == dout) begin
                    agree_ctr <= `CWF_CNT_ZERO;
                end else if (agree_ctr + `CWF_CNT_ONE >= agree_count) begin
                    dout      <= din; // R8
                    agree_ctr <= `CWF_CNT_ZERO;
                end else begin
                    agree_ctr <= agree_ctr + `CWF_CNT_ONE;
                end
            end
        end
    end
endmodule // cwf_sample_filter

// >>> rtl/cwf_compare_filter.v
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`include "cwf_defines.vh"
// Function
// R1 - Mode from enable, window, sample, count, period
// R2 - Disabled: output low, no processing
// R3 - Sampled modes bypass window gating
// R4 - Sample raw output on filter clock edges
// R5 - Filter when count>1 and period/external set
// R6 - Internal timebase samples every period cycles
// R7 - External strobe rising edge takes sample
// R8 - Change output after count agreeing samples
// R9 - Filtered output starts at zero
// R10 - Period and external zero disable filter
// R11 - Software disables filter before changing parameters
// R12 - Synchronize and edge-detect for flags
// R13 - Windowed: pass result only while window high
// R14 - Windowed: latch while window high, hold otherwise
// R15 - Windowed latency at most one cycle
// R16 - Resampled mode: count one, period spaced
// R17 - Windowed filtered latency bound
// R18 - Wait modes: keep running, irq wakes
// R19 - Stop: event wakes, pin still driven
// R20 - Stop speed follows speed select
// R21 - Reset restores all registers
// R22 - Debug mode: operation unchanged
// R23 - Irq when enable and flag both set
// R24 - Rise and fall flags from synchronized output
// R25 - Filter is counter, cleared when disabled
module cwf_compare_filter (
    input  wire                     pclk,                 // Bus clock, 100 MHz
    input  wire                     presetn,              // Async reset, low active
    input  wire                     ce,                   // Clock enable, freezes state
    input  wire                     psel,                 // APB select
    input  wire                     penable,              // APB enable
    input  wire                     pwrite,               // APB direction
    input  wire [`CWF_ADDR_W-1:0]   paddr,                // APB byte address
    input  wire [31:0]              pwdata,               // APB write data
    output reg  [31:0]              prdata,               // APB read data
    output reg                      pready,               // APB ready
    output reg                      pslverr,              // APB error
    input  wire                     analog_compare_out,   // Comparator result
    input  wire                     window_in,            // Window gate
    input  wire                     sample_strobe,        // External sample strobe
    output reg                      raw_compare_out,      // Unfiltered output
    output reg                      filtered_compare_out, // Filtered synchronized output
    output reg                      pin_out,              // External pin data
    output reg                      pin_out_en,           // External pin enable
    output reg                      speed_select,         // Comparator speed to analog
    output reg                      irq_req               // Interrupt / wake request
);
    // ==========================================================
    // Registers
    reg [`CWF_CNT_W-1:0] sample_agree_count;
    reg [7:0]            control_one;
    reg [`CWF_PER_W-1:0] sample_period_div;
    reg                  rise_flag;
    reg                  fall_flag;
    reg                  rise_irq_enable;
    reg                  fall_irq_enable;
    reg                  illegal_cfg;

    wire comp_enable            = control_one[`CWF_C1_EN];
    wire output_pin_enable      = control_one[`CWF_C1_OPE];
    wire window_enable          = control_one[`CWF_C1_WE];
    wire external_sample_enable = control_one[`CWF_C1_SE];

    // ==========================================================
    // Mode decode
    reg [`CWF_MODE_W-1:0] mode;
    wire cnt_zero = (sample_agree_count == `CWF_CNT_ZERO);
    wire cnt_one  = (sample_agree_count == `CWF_CNT_ONE);
    wire per_zero = (sample_period_div == `CWF_PER_ZERO);
    // Table of legal settings; anything else is flagged illegal
    always @* begin
        mode = `CWF_M_ILLEGAL; // R1
        if (!comp_enable)
            mode = `CWF_M_DISABLED; // R2
        else if (!window_enable) begin
            if (!external_sample_enable && (cnt_zero || per_zero))
                mode = `CWF_M_CONT;
            else if (cnt_one)
                mode = `CWF_M_SAMPLED;
            else if (!cnt_zero)
                mode = `CWF_M_SFILT; // R5
        end else if (!external_sample_enable) begin
            if (cnt_zero || per_zero)
                mode = `CWF_M_WINDOW;
            else if (cnt_one)
                mode = `CWF_M_WRESAMP; // R16
            else
                mode = `CWF_M_WFILT;
        end
    end

    wire windowed  = (mode == `CWF_M_WINDOW) || (mode == `CWF_M_WRESAMP) || (mode == `CWF_M_WFILT);
    wire sampling  = (mode == `CWF_M_SAMPLED) || (mode == `CWF_M_SFILT) ||
                     (mode == `CWF_M_WRESAMP) || (mode == `CWF_M_WFILT);
    wire filtering = (mode == `CWF_M_SFILT) || (mode == `CWF_M_WFILT); // R5

    // ==========================================================
    // Window latch; continuous and non-windowed sampled modes use the raw level
    reg  win_latch;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            win_latch <= 1'b0;
        else if (ce) begin
            if (!windowed)
                win_latch <= 1'b0;
            else if (window_in)
                win_latch <= analog_compare_out; // R14 R13 R15
        end
    end
    // Gated raw level: low when disabled, else comparator directly unless windowed
    wire raw_level = !comp_enable ? 1'b0 :                 // R2
                     windowed ? win_latch : analog_compare_out; // R3

    // ==========================================================
    // Sample tick sources
    reg [`CWF_PER_W-1:0] period_ctr;
    reg                  strobe_q;
    wire int_tick = sampling && !external_sample_enable && !per_zero &&
                    (period_ctr == `CWF_PER_ONE);
    wire ext_tick = sampling && external_sample_enable && sample_strobe && !strobe_q; // R7
    wire sample_tick = int_tick || ext_tick; // R4
    // Divided bus clock timebase; idle when no sampling to save switching
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_ctr <= `CWF_PER_ONE;
            strobe_q   <= 1'b0;
        end else if (ce) begin
            strobe_q <= sample_strobe;
            if (!sampling || external_sample_enable || per_zero)
                period_ctr <= `CWF_PER_ONE; // R10
            else if (period_ctr == `CWF_PER_ONE)
                period_ctr <= sample_period_div; // R6
            else
                period_ctr <= period_ctr - `CWF_PER_ONE;
        end
    end

    // ==========================================================
    // Sample/hold for non-filtered sampled modes
    reg held_sample;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            held_sample <= 1'b0;
        else if (ce) begin
            if (!sampling)
                held_sample <= 1'b0;
            else if (sample_tick)
                held_sample <= raw_level; // R4 R16
        end
    end

    wire filt_out;
    cwf_sample_filter u_filter (
        .pclk        (pclk),
        .presetn     (presetn),
        .ce          (ce),
        .active      (filtering), // R10
        .sample_tick (sample_tick),
        .din         (raw_level),
        .agree_count (sample_agree_count),
        .dout        (filt_out)     // R9
    );

    // Pre-synchronizer selection of the filter stage output
    wire stage_out = filtering ? filt_out :
                     (sampling ? held_sample : raw_level);

    // ==========================================================
    // Synchronizer and edge detection; first stage read only by the second
    reg sync_a;
    reg sync_b;
    reg sync_prev;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a    <= 1'b0;
            sync_b    <= 1'b0;
            sync_prev <= 1'b0;
        end else if (ce) begin
            sync_a    <= stage_out; // R12
            sync_b    <= sync_a;
            sync_prev <= sync_b;
        end
    end
    wire rise_evt = sync_b && !sync_prev; // R24
    wire fall_evt = !sync_b && sync_prev; // R24

    // ==========================================================
    // APB access
    wire wr_acc  = psel && penable && pwrite && pready;
    wire rd_setup = psel && !penable && !pwrite;
    wire addr_ok = (paddr == `CWF_ADDR_CTRL0) || (paddr == `CWF_ADDR_CTRL1) ||
                   (paddr == `CWF_ADDR_PERIOD) || (paddr == `CWF_ADDR_STATUS);
    // Write-one-to-clear on flags; a new edge in the same cycle wins
    wire clr_rise = wr_acc && (paddr == `CWF_ADDR_STATUS) && pwdata[`CWF_ST_RISE];
    wire clr_fall = wr_acc && (paddr == `CWF_ADDR_STATUS) && pwdata[`CWF_ST_FALL];

    // Register writes; illegal combos accepted but reported
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_agree_count <= `CWF_RST_CTRL0; // R21
            control_one        <= `CWF_RST_CTRL1;
            sample_period_div  <= `CWF_RST_PERIOD;
            rise_irq_enable    <= 1'b0;
            fall_irq_enable    <= 1'b0;
            rise_flag          <= 1'b0;
            fall_flag          <= 1'b0;
            illegal_cfg        <= 1'b0;
        end else if (ce) begin
            if (wr_acc && paddr == `CWF_ADDR_CTRL0)
                sample_agree_count <= pwdata[`CWF_CNT_MSB:`CWF_CNT_LSB]; // R11
            if (wr_acc && paddr == `CWF_ADDR_CTRL1)
                control_one <= pwdata[7:0];
            if (wr_acc && paddr == `CWF_ADDR_PERIOD)
                sample_period_div <= pwdata[`CWF_PER_MSB:0];
            if (wr_acc && paddr == `CWF_ADDR_STATUS) begin
                rise_irq_enable <= pwdata[`CWF_ST_RISE_IE];
                fall_irq_enable <= pwdata[`CWF_ST_FALL_IE];
            end
            if (rise_evt)
                rise_flag <= 1'b1; // R24
            else if (clr_rise)
                rise_flag <= 1'b0;
            if (fall_evt)
                fall_flag <= 1'b1; // R24
            else if (clr_fall)
                fall_flag <= 1'b0;
            illegal_cfg <= (mode == `CWF_M_ILLEGAL); // R1
        end
    end

    // ==========================================================
    // APB answer: one wait-free access, read data registered in setup
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (ce) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
            prdata  <= 32'h00000000;
            if (rd_setup) begin
                case (paddr)
                    `CWF_ADDR_CTRL0:  prdata[`CWF_CNT_MSB:`CWF_CNT_LSB] <= sample_agree_count;
                    `CWF_ADDR_CTRL1:  prdata[7:0] <= control_one;
                    `CWF_ADDR_PERIOD: prdata[`CWF_PER_MSB:0] <= sample_period_div;
                    `CWF_ADDR_STATUS: prdata <= {23'h000000, illegal_cfg, mode,
                                      rise_irq_enable, fall_irq_enable,
                                      rise_flag, fall_flag, sync_b};
                    default:          prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================================
    // Outputs; no clock gating, so wait, stop and debug run unchanged
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            raw_compare_out      <= 1'b0;
            filtered_compare_out <= 1'b0;
            pin_out              <= 1'b0;
            pin_out_en           <= 1'b0;
            speed_select         <= 1'b0;
            irq_req              <= 1'b0;
        end else if (ce) begin
            raw_compare_out      <= raw_level; // R2 R22
            filtered_compare_out <= sync_b; // R12 R17
            pin_out              <= sync_b; // R19
            pin_out_en           <= output_pin_enable && comp_enable; // R19
            speed_select         <= control_one[`CWF_C1_SPEED]; // R20
            irq_req              <= (rise_irq_enable && (rise_flag || rise_evt)) ||
                                    (fall_irq_enable && (fall_flag || fall_evt)); // R23 R18
        end
    end
endmodule // cwf_compare_filter

// >>> sim/cwf_compare_filter_assertions.sv
`timescale 1ns/1ns
// ==========================================================
// Port checker for the comparator filter
module cwf_compare_filter_assertions (
    input wire        pclk,                 // Bus clock
    input wire        presetn,              // Reset, low active
    input wire        psel,                 // APB select
    input wire        penable,              // APB enable
    input wire        pwrite,               // APB direction
    input wire        pready,               // APB ready
    input wire [7:0]  paddr,                // APB address
    input wire [31:0] pwdata,               // APB write data
    input wire        analog_compare_out,   // Comparator result
    input wire        window_in,            // Window gate
    input wire        raw_compare_out,      // Raw output
    input wire        filtered_compare_out, // Filtered output
    input wire        pin_out_en,           // Pin enable
    input wire        speed_select,         // Speed select
    input wire        irq_req               // Interrupt request
);
    reg  en_s, we_s, se_s, ope_s, spd_s, rie_s, fie_s;   // Shadow control bits
    wire wr  = psel && penable && pready && pwrite;     // Write lands
    wire win = en_s && we_s && !se_s;                   // Legal windowed mode
    // Shadow the control writes so enable, window and external sample select are known from the ports alone
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {en_s, we_s, se_s, ope_s, spd_s, rie_s, fie_s} <= 7'h00;
        end else if (wr && paddr == 8'h04) begin
            {en_s, we_s, se_s, ope_s, spd_s} <= {pwdata[0], pwdata[6], pwdata[7], pwdata[1], pwdata[4]};
        end else if (wr && paddr == 8'h0c) begin
            {rie_s, fie_s} <= {pwdata[4], pwdata[3]};
        end
    end
    default clocking dc @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_disabled_low: assert property (!en_s [*6] |-> !raw_compare_out && !filtered_compare_out)
        else $error("output not low while disabled");
    a_cont_follow: assert property (en_s && !we_s && $past(en_s && !we_s)
        |-> raw_compare_out == $past(analog_compare_out)) else $error("raw output lost comparator");
    a_window_hold: assert property (win && $past(win, 3) && !window_in && !$past(window_in)
        && !$past(window_in, 2) |-> $stable(raw_compare_out)) else $error("raw moved with window shut");
    a_window_pass: assert property (win && $past(win, 3) && $past(window_in) && $past(window_in, 2)
        |-> raw_compare_out == $past(analog_compare_out, 2)) else $error("raw not passed in window");
    a_rise_irq: assert property (rie_s && $rose(filtered_compare_out) |-> ##[0:3] irq_req)
        else $error("no request on rising edge");
    a_fall_irq: assert property (fie_s && $fell(filtered_compare_out) |-> ##[0:3] irq_req)
        else $error("no request on falling edge");
    a_pin_enable: assert property ($stable(en_s && ope_s) |-> pin_out_en == (en_s && ope_s))
        else $error("pin enable wrong");
    a_speed_copy: assert property ($stable(spd_s) |-> speed_select == spd_s)
        else $error("speed select wrong");
endmodule // cwf_compare_filter_assertions

// >>> sim/cwf_analog_src.sv
`timescale 1ns/1ns
// ==========================================================
// Far side: comparator level, window gate, sample strobe
module cwf_analog_src (
    input  wire       pclk,               // Bus clock
    input  wire       level,              // Level to present
    input  wire       win_req,            // Window to present
    input  wire [3:0] strobe_half,        // Strobe half period, 0 parks it
    output reg        analog_compare_out, // Comparator result
    output reg        window_in,          // Window gate
    output reg        sample_strobe       // External sample clock
);
    reg [3:0] ph; // Strobe phase count
    // Defined levels from time zero
    initial begin
        analog_compare_out = 1'h0;
        window_in = 1'h0;
        sample_strobe = 1'h0;
        ph = 4'h0;
    end
    // Whole-cycle strobe phases, so no rising edge can slip by
    always @(posedge pclk) begin
        analog_compare_out <= level;
        window_in <= win_req;
        ph <= (ph + 4'h1 >= strobe_half) ? 4'h0 : ph + 4'h1;
        if (strobe_half == 4'h0) begin
            sample_strobe <= 1'h0;
        end else if (ph + 4'h1 >= strobe_half) begin
            sample_strobe <= !sample_strobe;
        end
    end
endmodule // cwf_analog_src

// >>> sim/comparator_window_sample_filter_bench.sv
`timescale 1ns/1ns
// ==========================================================
// Self-checking bench for the comparator filter
module comparator_window_sample_filter_bench;
    reg         pclk, presetn, ce, psel, penable, pwrite, level, win_req, err, r0;
    reg  [7:0]  paddr, seed, c1, pp;
    reg  [2:0]  cc, m;
    reg  [3:0]  strobe_half;
    reg  [31:0] pwdata, rd;
    wire [31:0] prdata;
    wire        pready, pslverr, analog_compare_out, window_in, sample_strobe, raw_compare_out;
    wire        filtered_compare_out, pin_out, pin_out_en, speed_select, irq_req;
    integer     num_errors, tests_run, i, n;
    cwf_compare_filter i_cwf_compare_filter (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .analog_compare_out, .window_in, .sample_strobe,
        .raw_compare_out, .filtered_compare_out, .pin_out, .pin_out_en, .speed_select, .irq_req);
    cwf_analog_src i_cwf_analog_src (.pclk, .level, .win_req, .strobe_half, .analog_compare_out,
        .window_in, .sample_strobe);
    // Bus clock, 10 ns
    initial begin
        pclk = 1'h0;
        forever #5 pclk = ~pclk;
    end
    // Hang guard, far beyond the thousand or so cycles needed
    initial begin
        #300000;
        num_errors = num_errors + 1;
        results;
    end
    function [7:0] lfsr(input [7:0] s);
        lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Mode expected from enable, window, external, count and period
    function [2:0] exp_mode(input [2:0] c, input [7:0] x, input [7:0] p); begin
        if (!x[0]) exp_mode = 3'h0;
        else if (x[6] && x[7]) exp_mode = 3'h7;
        else if (x[6]) exp_mode = (c == 0 || p == 0) ? 3'h4 : (c == 1) ? 3'h5 : 3'h6;
        else if (x[7]) exp_mode = (c == 0) ? 3'h7 : (c == 1) ? 3'h2 : 3'h3;
        else exp_mode = (c == 0 || p == 0) ? 3'h1 : (c == 1) ? 3'h2 : 3'h3;
    end endfunction
    task chk(input [31:0] got, input [31:0] exp); begin
        tests_run = tests_run + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    end endtask
    // One APB transfer, held until pready is seen at an edge
    task apb(input w, input [7:0] a, input [31:0] d); begin
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    end endtask
    // Park in the disabled setting before moving any filter field
    task cfg(input [2:0] c, input [7:0] x, input [7:0] p); begin
        apb(1, 8'h04, {24'h0, x & 8'h7e});
        apb(1, 8'h08, 32'h0);
        apb(1, 8'h00, {25'h0, c, 4'h0});
        apb(1, 8'h08, {24'h0, p});
        apb(1, 8'h04, {24'h0, x});
    end endtask
    task meas(input v, input integer lo, input integer hi); begin
        n = 0;
        while (filtered_compare_out !== v && n < 300) begin
            @(posedge pclk);
            n = n + 1;
        end
        chk(n >= lo && n <= hi, 1);
    end endtask
    // Rise then fall; strobe period is six cycles
    task step(input [2:0] c, input [7:0] x, input [7:0] p); integer lo, hi; begin
        lo = (c - 1) * (x[7] ? 6 : p);
        hi = lo + (x[7] ? 6 : p) + 10;
        level <= 1'h1;
        cfg(c, x, p);
        meas(1'h1, lo, hi);
        level <= 1'h0;
        meas(1'h0, lo, hi);
    end endtask
    task rnd(input integer k); begin
        repeat (k) begin
            @(posedge pclk);
            seed = lfsr(seed);
            level <= seed[0];
        end
    end endtask
    task results; begin
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    end endtask
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, level, win_req} = 6'h00;
        ce = 1'h1;
        paddr = 8'h00;
        pwdata = 32'h0;
        strobe_half = 4'h3;
        seed = 8'h59;
        num_errors = 0;
        tests_run = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        for (i = 0; i < 4; i = i + 1) begin
            apb(0, {i[5:0], 2'h0}, 32'h0);
            chk(rd, 0);
        end
        apb(0, 8'h10, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
        for (i = 0; i < 24; i = i + 1) begin
            seed = lfsr(seed);
            cc = {1'h0, seed[1:0]};
            c1 = {seed[4:3], 5'h00, |seed[6:5]};
            pp = {6'h00, seed[7:6]};
            cfg(cc, c1, pp);
            apb(0, 8'h0c, 32'h0);
            m = exp_mode(cc, c1, pp);
            chk(rd[8:5], {m == 3'h7, m});
        end
        cfg(3'h0, 8'h01, 8'h00);
        rnd(40);
        repeat (6) @(posedge pclk);
        chk(filtered_compare_out, level);
        level <= 1'h1;
        cfg(3'h0, 8'h00, 8'h00);
        repeat (8) @(posedge pclk);
        chk({raw_compare_out, filtered_compare_out}, 0);
        cfg(3'h0, 8'h41, 8'h00);
        repeat (4) @(posedge pclk);
        r0 = raw_compare_out;
        rnd(20);
        chk(raw_compare_out, r0);
        win_req <= 1'h1;
        rnd(20);
        repeat (4) @(posedge pclk);
        chk(raw_compare_out, level);
        step(3'h3, 8'h01, 8'h04);
        step(3'h1, 8'h01, 8'h06);
        step(3'h2, 8'h81, 8'h00);
        strobe_half <= 4'h0;
        level <= 1'h1;
        repeat (40) @(posedge pclk);
        chk(filtered_compare_out, 0);
        strobe_half <= 4'h3;
        meas(1'h1, 1, 30);
        step(3'h1, 8'h41, 8'h05);
        step(3'h3, 8'h41, 8'h02);
        cfg(3'h0, 8'h13, 8'h00);
        apb(1, 8'h0c, 32'h16);
        level <= 1'h1;
        repeat (8) @(posedge pclk);
        chk(irq_req, 1);
        apb(0, 8'h0c, 32'h0);
        chk(rd[2:0], 3'h5);
        chk({pin_out, pin_out_en, speed_select}, 3'h7);
        apb(1, 8'h0c, 32'h0c);
        repeat (2) @(posedge pclk);
        chk(irq_req, 0);
        level <= 1'h0;
        repeat (8) @(posedge pclk);
        chk(irq_req, 1);
        apb(0, 8'h0c, 32'h0);
        chk(rd[2:0], 3'h2);
        chk(pin_out, 0);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        apb(0, 8'h04, 32'h0);
        chk(rd, 0);
        results;
    end
endmodule // comparator_window_sample_filter_bench
bind cwf_compare_filter cwf_compare_filter_assertions i_cwf_compare_filter_assertions (.pclk, .presetn, .psel,
    .penable, .pwrite, .pready, .paddr, .pwdata, .analog_compare_out, .window_in, .raw_compare_out,
    .filtered_compare_out, .pin_out_en, .speed_select, .irq_req);
